// file: src/memory_partition_erase_lock.sv
// Purpose: erase lock, data address decode, reset pin and clock select
// Assumes: flash array and RAM sit outside, driven by the strobes here
// Notes:   engine RAM protection is trusted to software, not enforced
`timescale 1ns/1ps
module memory_partition_erase_lock
   import mem_part_pkg::*;
(
   input  wire logic        clk,           // System clock
   input  wire logic        resetn,        // Internal reset, active low
   input  wire erase_req_s  erase_req,     // Erase request from core/debug
   output erase_rsp_s       erase_rsp,     // Erase answer
   input  wire logic        d_en,          // Data access strobe
   input  wire logic        d_we,          // Data write
   input  wire logic [11:0] d_addr,        // Data address
   input  wire logic [7:0]  d_wdata,       // Write data
   output logic [7:0]       d_rdata,       // Read data
   output logic             d_ready,       // Access done pulse
   output region_e          d_region,      // Region of current access
   output logic             ram_we,        // RAM write strobe
   output logic             ram_en,        // RAM select
   output logic             creg_en,       // Control register select
   input  wire logic [7:0]  ram_rdata,     // RAM read data
   input  wire logic [7:0]  creg_rdata,    // Control register read data
   input  wire logic        rst_pin_in,    // Reset pin level
   output logic             rst_pin_out,   // Reset pin drive value
   output logic             rst_pin_oe,    // Reset pin drive enable
   output logic             dev_reset_req, // Device reset request
   input  wire logic        osc_input_pin, // Oscillator/RC/driver input
   input  wire logic        ext_clock_pin, // TTL clock input
   input  wire logic        clk_sel,       // 1 selects the clock pin
   output logic             sys_clk_src    // Chosen clock source
);
   logic       rpin_s1_r;    // First sync stage
   logic       rpin_s2_r;    // Second sync stage
   logic [2:0] hold_r;       // Reset pin stretch counter
   logic [2:0] hold_nxt;
   region_e    reg_cls;      // Decoded region
   logic       in_fw;        // Erase address inside firmware

   // Reset pin sampled through two flops before use
   always_ff @(posedge clk) begin
      rpin_s1_r <= rst_pin_in;
      rpin_s2_r <= rpin_s1_r;
   end

   assign dev_reset_req = !rpin_s2_r;

   // Limitation: the pin reads back our own pull as a low level, so
   // whatever turns dev_reset_req into resetn must mask it while oe is high
   // Stretch so the pin stays low a little after internal reset ends
   always_comb begin
      if (!resetn || !rpin_s2_r) begin
         hold_nxt = 3'(RST_HOLD);
      end else if (hold_r != 3'h0) begin
         hold_nxt = hold_r - 3'h1;
      end else begin
         hold_nxt = 3'h0;
      end
   end

   // Stretch counter; no reset branch, the comb side reloads it in reset
   always_ff @(posedge clk) begin
      hold_r <= hold_nxt;
   end

   always_comb begin
      rst_pin_out = 1'b0;
      rst_pin_oe  = !resetn || (hold_r != 3'h0);
   end

   always_comb begin
      sys_clk_src = clk_sel ? ext_clock_pin : osc_input_pin;
   end

   // Firmware region test; upper bound is the top of flash
   assign in_fw = (erase_req.addr >= FW_LO) && (erase_req.addr <= FW_HI);

   // Erase answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (!resetn) begin
         erase_rsp <= '0;
      end else begin
         erase_rsp <= '0;
         if (erase_req.valid) begin
            erase_rsp.done <= 1'b1;
            case (erase_req.kind)
               ER_MASS: begin
                  erase_rsp.clear_user <= 1'b1;
                  erase_rsp.page_addr  <= USER_LO;
               end
               ER_PAGE: begin
                  erase_rsp.refused   <= in_fw;
                  erase_rsp.page_addr <= erase_req.addr;
               end
               default: erase_rsp.refused <= 1'b1;
            endcase
         end
      end
   end

   // Data address decode
   always_comb begin
      if (d_addr <= APP0_HI) begin
         reg_cls = REG_APP;                 // low app range
      end else if (d_addr < WIN_LO) begin
         reg_cls = REG_ENGINE;              // engine private
      end else if (d_addr <= ADV_HI) begin
         reg_cls = REG_ADV;                 // advanced window
      end else if (d_addr <= WIN_HI) begin
         reg_cls = REG_SHARED;              // shared window
      end else if (d_addr <= APP1_HI) begin
         reg_cls = REG_APP;                 // second app range
      end else if (d_addr <= RAM_HI) begin
         reg_cls = REG_ENGINE;              // engine private
      end else if (d_addr < CREG_LO) begin
         reg_cls = REG_EMPTY;               // unbacked gap
      end else begin
         reg_cls = REG_CTRL;                // control page
      end
   end

   // no strobe reaches storage in gap
   always_comb begin
      ram_en  = d_en && (reg_cls != REG_EMPTY) && (reg_cls != REG_CTRL);
      ram_we  = ram_en && d_we;
      creg_en = d_en && (reg_cls == REG_CTRL);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         d_rdata  <= 8'h00;
         d_ready  <= 1'b0;
         d_region <= REG_APP;
      end else begin
         d_ready  <= d_en;
         d_region <= reg_cls;
         if (d_en && !d_we) begin
            case (reg_cls)
               REG_EMPTY: d_rdata <= EMPTY_DATA;
               REG_CTRL:  d_rdata <= creg_rdata;
               default:   d_rdata <= ram_rdata;
            endcase
         end
      end
   end

   // Assertions

   // Page erase presented this cycle
   sequence page_req_s;
      erase_req.valid && erase_req.kind == ER_PAGE;
   endsequence

   // Mass erase presented this cycle
   sequence mass_req_s;
      erase_req.valid && erase_req.kind == ER_MASS;
   endsequence

   // Internal reset just let go
   sequence rst_rel_s;
      !resetn ##1 resetn;
   endsequence

   // Release, then a quiet pin for the whole stretch and one cycle more
   sequence rst_quiet_s;
      !resetn ##1 (resetn && rpin_s2_r) [*5];
   endsequence

   locked_page_a: assert property (
      @(posedge clk) disable iff (!resetn)
      page_req_s ##0 in_fw |=> erase_rsp.done && erase_rsp.refused)
      else $error("locked page erase not refused");
   user_page_a: assert property (
      @(posedge clk) disable iff (!resetn)
      page_req_s ##0 (erase_req.addr <= USER_HI)
      |=> erase_rsp.done && !erase_rsp.refused)
      else $error("user page erase refused");
   debug_page_a: assert property (
      @(posedge clk) disable iff (!resetn)
      page_req_s ##0 (erase_req.from_debug && in_fw)
      |=> erase_rsp.refused && !erase_rsp.clear_user)
      else $error("debug page erase reached firmware");
   mass_user_a: assert property (
      @(posedge clk) disable iff (!resetn)
      mass_req_s |=> erase_rsp.done && erase_rsp.clear_user
      && !erase_rsp.refused)
      else $error("mass erase wrong");
   debug_mass_a: assert property (
      @(posedge clk) disable iff (!resetn)
      erase_rsp.clear_user |-> erase_rsp.page_addr < FW_LO)
      else $error("mass erase touched firmware");
   gap_nostore_a: assert property (
      @(posedge clk) disable iff (!resetn)
      d_en && d_addr >= GAP_LO && d_addr <= GAP_HI
      |-> !ram_en && !creg_en)
      else $error("gap access reached storage");
   gap_read_a: assert property (
      @(posedge clk) disable iff (!resetn)
      d_en && !d_we && d_addr >= GAP_LO && d_addr <= GAP_HI
      |=> d_ready && d_rdata == EMPTY_DATA)
      else $error("gap read value wrong");
   ctrl_page_a: assert property (
      @(posedge clk) disable iff (!resetn)
      d_en && d_addr >= CREG_LO |-> creg_en)
      else $error("control page not selected");
   app_ram_a: assert property (
      @(posedge clk) disable iff (!resetn)
      d_en && d_addr >= APP1_LO && d_addr <= APP1_HI
      |-> ram_en && reg_cls == REG_APP)
      else $error("app range not mapped");
   adv_win_a: assert property (
      @(posedge clk) disable iff (!resetn)
      d_en && d_addr >= WIN_LO && d_addr <= ADV_HI
      |-> reg_cls == REG_ADV)
      else $error("advanced window misdecoded");
   // Two sync stages, so the request shows two edges after the pin
   pin_reset_a: assert property (
      @(posedge clk)
      !rst_pin_in |-> ##2 dev_reset_req)
      else $error("pin low gave no reset");
   pin_drive_a: assert property (
      @(posedge clk)
      !resetn |-> rst_pin_oe && !rst_pin_out)
      else $error("reset pin not pulled low");
   // Pin stays pulled for the stretch after internal reset ends
   pin_hold_a: assert property (
      @(posedge clk)
      rst_rel_s |-> rst_pin_oe [*4])
      else $error("reset pin released early");
   // And lets go once the stretch has run out on a quiet pin
   pin_free_a: assert property (
      @(posedge clk)
      rst_quiet_s |-> !rst_pin_oe)
      else $error("reset pin held too long");
endmodule // memory_partition_erase_lock

// file: src/mem_part_pkg.sv
// Purpose: constants and carriers for the memory partition and erase lock
// Assumes: 13-bit program flash space, 12-bit data space, byte data
// Notes:   all region bounds live here; the design names them only
// Overview of operation
// - User erase inside firmware region refused
// - Debug mass and page erase spare firmware
// - Low 2KB flash open to user code
// - Two application RAM ranges, 256 bytes total
// - Top data page decodes to control registers
// - Gap above RAM holds no storage
// - Engine and application share one RAM window
// - Advanced configuration in window's lower sixteen
// - Low reset pin puts device in reset
// - Device pulls reset pin low in reset
// - Clock from oscillator pin or clock pin
package mem_part_pkg;
   // Program flash bounds
   localparam logic [12:0] USER_LO     = 13'h0000;
   localparam logic [12:0] USER_HI     = 13'h07FF;
   localparam logic [12:0] FW_LO       = 13'h0800;
   localparam logic [12:0] FW_HI       = 13'h1FFF;
   // Data space bounds
   localparam logic [11:0] APP0_HI     = 12'h07F;
   localparam logic [11:0] ENG0_LO     = 12'h080;
   localparam logic [11:0] WIN_LO      = 12'h0F0;
   localparam logic [11:0] ADV_HI      = 12'h0FF;
   localparam logic [11:0] WIN_HI      = 12'h10F;
   localparam logic [11:0] APP1_LO     = 12'h110;
   localparam logic [11:0] APP1_HI     = 12'h18F;
   localparam logic [11:0] ENG1_LO     = 12'h190;
   localparam logic [11:0] RAM_HI      = 12'h3FF;
   localparam logic [11:0] GAP_LO      = 12'h400;
   localparam logic [11:0] GAP_HI      = 12'hEFF;
   localparam logic [11:0] CREG_LO     = 12'hF00;
   // Fixed read value of empty space
   localparam logic [7:0]  EMPTY_DATA  = 8'hFF;
   // Reset pin held low this many cycles after the cause goes away
   localparam int unsigned RST_HOLD    = 4;

   // Data region classes
   typedef enum logic [2:0] {
      REG_APP, REG_ENGINE, REG_ADV, REG_SHARED, REG_CTRL, REG_EMPTY
   } region_e;
   // Erase kinds
   typedef enum logic [1:0] {
      ER_PAGE, ER_MASS
   } erase_kind_e;
   // Erase request carrier
   typedef struct packed {
      logic        valid;
      logic        from_debug;
      erase_kind_e kind;
      logic [12:0] addr;
   } erase_req_s;
   // Erase answer carrier
   typedef struct packed {
      logic        done;
      logic        refused;
      logic        clear_user;
      logic [12:0] page_addr;
   } erase_rsp_s;
endpackage

// file: dv/erase_requester.sv
// Purpose: model of the core and debug port issuing erase requests
// Assumes: requests change at the falling edge and last one cycle
// Notes:   answer is read half a cycle after the request is taken
`timescale 1ns/1ps
module erase_requester
   import mem_part_pkg::*;
(
   input  wire logic clk,       // System clock
   input  erase_rsp_s erase_rsp, // Answer from the lock
   output erase_req_s erase_req  // Request to the lock
);
   // Idle until a task call
   initial erase_req = '0;

   task automatic issue(input logic by_debug, input erase_kind_e k,
                        input logic [12:0] a, output erase_rsp_s r);
      @(negedge clk);
      erase_req <= '{1'b1, by_debug, k, a};
      @(negedge clk);
      erase_req <= '0;
      // Answer stands one cycle only, so take it now
      r = erase_rsp;
   endtask
endmodule // erase_requester

// file: dv/test_memory_partition_erase_lock.sv
// Purpose: self-checking bench for the partition and erase lock
// Assumes: RAM and control registers answer with address patterns
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ps
module test_memory_partition_erase_lock;
   import mem_part_pkg::*;
   logic        clk = 0, resetn = 0, d_en = 0, d_we = 0;
   logic        rst_pin_in = 1, osc_input_pin = 0;
   logic        ext_clock_pin = 0, clk_sel = 0;
   logic [11:0] d_addr = '0;
   logic [7:0]  d_wdata = '0, d_rdata, ram_rdata, creg_rdata;
   erase_req_s  erase_req;
   erase_rsp_s  erase_rsp;
   region_e     d_region;
   logic        d_ready, ram_we, ram_en, creg_en, rst_pin_out;
   logic        rst_pin_oe, dev_reset_req, sys_clk_src;
   int          errors = 0, check_count = 0, cycles = 0;

   // 10 MHz clock
   always #50 clk = ~clk;
   // Outside storage answers with address patterns
   assign ram_rdata  = d_addr[7:0] ^ 8'h5A;
   assign creg_rdata = ~d_addr[7:0];

   memory_partition_erase_lock u_memory_partition_erase_lock (.clk,
      .resetn, .erase_req, .erase_rsp, .d_en, .d_we, .d_addr, .d_wdata,
      .d_rdata, .d_ready, .d_region, .ram_we, .ram_en, .creg_en,
      .ram_rdata, .creg_rdata, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
      .dev_reset_req, .osc_input_pin, .ext_clock_pin, .clk_sel,
      .sys_clk_src);
   erase_requester u_erase_requester (.clk, .erase_rsp, .erase_req);

   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Region edges on both sides, page and mass erase
   task t_erase;
      erase_rsp_s  r;
      logic [12:0] a [6] = '{13'h0000, 13'h07FF, 13'h0800,
                             13'h1FFF, 13'h0900, 13'h0123};
      for (int i = 0; i < 6; i++) begin
         u_erase_requester.issue(i[0], ER_PAGE, a[i], r);
         chk(r, {1'b1, a[i] >= FW_LO, 1'b0, a[i]});
      end
      for (int i = 0; i < 2; i++) begin
         u_erase_requester.issue(i[0], ER_MASS, 13'h1000, r);
         chk(r, {3'b101, 13'h0000});
      end
   endtask

   // One data access; strobes checked in cycle, answer the next
   task automatic acc(input logic we, input logic [11:0] a,
                      input region_e rg);
      logic re;
      logic [7:0] ex;
      re = !(rg inside {REG_EMPTY, REG_CTRL});
      ex = rg == REG_EMPTY ? EMPTY_DATA :
           rg == REG_CTRL ? ~a[7:0] : a[7:0] ^ 8'h5A;
      @(negedge clk);
      d_en <= 1'b1;
      d_we <= we;
      d_addr <= a;
      d_wdata <= a[7:0];
      #1;
      chk({13'h0, ram_en, ram_we, creg_en},
          {13'h0, re, re & we, rg == REG_CTRL});
      @(negedge clk);
      d_en <= 1'b0;
      d_we <= 1'b0;
      chk({d_ready, 4'h0, d_region, we ? 8'h0 : d_rdata},
          {1'b1, 4'h0, rg, we ? 8'h0 : ex});
   endtask

   // Decode the region edges but 000 and 0EF, one idle cycle between accesses
   task t_decode;
      logic [11:0] a [14] = '{12'h07F, 12'h080, 12'h0F0, 12'h0FF,
         12'h100, 12'h10F, 12'h110, 12'h18F, 12'h190, 12'h3FF,
         12'h400, 12'hEFF, 12'hF00, 12'hFFF};
      region_e e [14] = '{REG_APP, REG_ENGINE, REG_ADV, REG_ADV,
         REG_SHARED, REG_SHARED, REG_APP, REG_APP, REG_ENGINE,
         REG_ENGINE, REG_EMPTY, REG_EMPTY, REG_CTRL, REG_CTRL};
      for (int i = 0; i < 14; i++) acc(1'b0, a[i], e[i]);
      acc(1'b1, 12'h110, REG_APP);
      acc(1'b1, 12'h400, REG_EMPTY);
      acc(1'b1, 12'hF00, REG_CTRL);
   endtask

   // Pin pulled low from outside, then internal reset
   task t_rst;
      @(negedge clk) rst_pin_in <= 1'b0;
      repeat (3) @(negedge clk);
      chk({14'h0, dev_reset_req, rst_pin_oe}, 16'h0003);
      rst_pin_in <= 1'b1;
      repeat (3) @(negedge clk);
      chk({14'h0, dev_reset_req, rst_pin_out}, 16'h0000);
      resetn <= 1'b0;
      repeat (2) @(negedge clk);
      chk({14'h0, rst_pin_oe, rst_pin_out}, 16'h0002);
      resetn <= 1'b1;
      // Last cycle of the stretch, then the first one free
      repeat (RST_HOLD - 1) @(negedge clk);
      chk({15'h0, rst_pin_oe}, 16'h0001);
      repeat (1) @(negedge clk);
      chk({15'h0, rst_pin_oe}, 16'h0000);
   endtask

   // All source select and level combinations
   task t_clk;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         {clk_sel, ext_clock_pin, osc_input_pin} = i[2:0];
         #1;
         chk({15'h0, sys_clk_src}, {15'h0, i[2] ? i[1] : i[0]});
      end
   endtask

   // Main sequence after 8 cycles of reset
   initial begin
      repeat (8) @(negedge clk);
      resetn <= 1'b1;
      t_erase;
      t_decode;
      t_rst;
      t_clk;
      close_out;
   end

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         close_out;
      end
   end
endmodule // test_memory_partition_erase_lock
